// *** src/duafr_defs.vh ***
// constants for the dual uart alternate function and reset bank
`ifndef DUAFR_DEFS_VH
`define DUAFR_DEFS_VH
`define DUAFR_OFS_IER      3'h1
`define DUAFR_OFS_ISR      3'h2
`define DUAFR_OFS_FCR      3'h2
`define DUAFR_OFS_AFR      3'h2
`define DUAFR_OFS_LCR      3'h3
`define DUAFR_OFS_MCR      3'h4
`define DUAFR_OFS_LSR      3'h5
`define DUAFR_OFS_MSR      3'h6
`define DUAFR_LCR_DLAB     7
`define DUAFR_AFR_CONC     0
`define DUAFR_AFR_MF_LO    1
`define DUAFR_AFR_MF_HI    2
`define DUAFR_AFR_MASK     8'h07
`define DUAFR_RST_ZERO     8'h00
`define DUAFR_RST_ISR      8'h01
`define DUAFR_RST_LSR      8'h60
`define DUAFR_MF_OP2       2'h0
`define DUAFR_MF_BAUD      2'h1
`define DUAFR_MF_RECEIVE_READY_OUT     2'h2
`define DUAFR_MF_RSVD      2'h3
`define DUAFR_MCR_OP2      3
`define DUAFR_MCR_RTS      1
`define DUAFR_MCR_DTR      0
`define DUAFR_SYNC_STAGES  3
`endif

// *** src/duafr_sync.v ***
// three-stage input synchroniser, change taken when stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module duafr_sync #(
  parameter W = 4
) (
  // clock and reset
  input  wire         clk_sys_i,
  input  wire         rst_b_i,
  // data
  input  wire [W-1:0] async_i,
  output reg  [W-1:0] sync_o
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_r   <= {W{1'b0}};
      s2_r   <= {W{1'b0}};
      s3_r   <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // filter: only agreed bits move the output
      sync_o <= (s2_r & s3_r) | (sync_o & (s2_r | s3_r));
    end
  end
endmodule // duafr_sync
`default_nettype wire

// *** src/duafr_chan.v ***
// per-channel control registers, modem status and pin outputs
`timescale 1ns/1ns
`default_nettype none
`include "duafr_defs.vh"
module duafr_chan (
  // clock and reset
  input  wire       clk_sys_i,
  input  wire       rst_b_i,
  // register access
  input  wire       wr_i,
  input  wire       rd_i,
  input  wire [2:0] addr_i,
  input  wire [7:0] wdata_i,
  output reg  [7:0] rdata_o,
  // shared alternate function value, one copy for both channels
  input  wire [7:0] afr_i,
  // synchronised modem inputs, active high: cd ri dsr cts
  input  wire [3:0] modem_i,
  // live status from the datapath
  input  wire       baud_i,
  input  wire       rx_ready_i,
  input  wire       tx_ready_i,
  input  wire       tx_serial_i,
  // pin outputs
  output reg        serial_o,
  output reg        op2_o,
  output reg        rts_o,
  output reg        dtr_o,
  output reg        irq_o,
  output reg        txrdy_o,
  output reg        mf_o,
  output wire [7:0] lcr_o
);
  reg  [7:0] ier_r;
  reg  [7:0] lcr_r;
  reg  [7:0] mcr_r;
  reg  [7:0] fcr_r;
  reg  [7:0] lsr_r;
  reg  [3:0] dmsr_r;
  reg  [3:0] mprev_r;
  reg        seen_r;
  wire       dlab;
  wire [3:0] chg;
  wire       msr_rd;
  wire       mf_sel;
  assign dlab   = lcr_r[`DUAFR_LCR_DLAB];
  assign lcr_o  = lcr_r;
  assign msr_rd = rd_i && (addr_i == `DUAFR_OFS_MSR);
  // ri flags only on a trailing edge of ring, others on any change
  assign chg    = seen_r ? {modem_i[3] ^ mprev_r[3], ~modem_i[2] & mprev_r[2],
                            modem_i[1:0] ^ mprev_r[1:0]} : 4'h0;
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ier_r   <= `DUAFR_RST_ZERO;
      lcr_r   <= `DUAFR_RST_ZERO;
      mcr_r   <= `DUAFR_RST_ZERO;
      fcr_r   <= `DUAFR_RST_ZERO;
      lsr_r   <= `DUAFR_RST_LSR;
      dmsr_r  <= 4'h0;
      mprev_r <= 4'h0;
      seen_r  <= 1'b0;
    end else begin
      mprev_r <= modem_i;
      seen_r  <= 1'b1;
      if (wr_i) begin
        case (addr_i)
          `DUAFR_OFS_IER: begin
            if (!dlab) ier_r <= wdata_i;
          end
          `DUAFR_OFS_FCR: begin
            if (!dlab) fcr_r <= wdata_i;
          end
          `DUAFR_OFS_LCR: begin
            lcr_r <= wdata_i;
          end
          `DUAFR_OFS_MCR: begin
            mcr_r <= wdata_i;
          end
          default: begin
          end
        endcase
      end
      // a change that lands on the read is kept for the next read
      dmsr_r <= (msr_rd ? 4'h0 : dmsr_r) | chg;
    end
  end
  // reads: msr upper nibble follows the inputs even straight after reset
  always @* begin
    rdata_o = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `DUAFR_OFS_IER: rdata_o = dlab ? 8'h00 : ier_r;
        `DUAFR_OFS_ISR: rdata_o = dlab ? afr_i : (irq_o ? 8'h00 : `DUAFR_RST_ISR);
        `DUAFR_OFS_LCR: rdata_o = lcr_r;
        `DUAFR_OFS_MCR: rdata_o = mcr_r;
        `DUAFR_OFS_LSR: rdata_o = lsr_r;
        `DUAFR_OFS_MSR: rdata_o = {modem_i, dmsr_r};
        default:        rdata_o = 8'h00;
      endcase
    end
  end
  // reserved select parks the pin at its inactive high level
  function mf_pick;
    input [1:0] sel;
    input       op2;
    input       baud;
    input       rxr;
    begin
      case (sel)
        `DUAFR_MF_OP2:   mf_pick = op2;
        `DUAFR_MF_BAUD:  mf_pick = baud;
        `DUAFR_MF_RECEIVE_READY_OUT: mf_pick = rxr;
        default:         mf_pick = 1'b1;
      endcase
    end
  endfunction
  assign mf_sel = mf_pick(afr_i[`DUAFR_AFR_MF_HI:`DUAFR_AFR_MF_LO], ~mcr_r[`DUAFR_MCR_OP2],
                          baud_i, ~rx_ready_i);
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      serial_o <= 1'b1;
      op2_o    <= 1'b1;
      rts_o    <= 1'b1;
      dtr_o    <= 1'b1;
      irq_o    <= 1'b0;
      txrdy_o  <= 1'b0;
      mf_o     <= 1'b1;
    end else begin
      serial_o <= tx_serial_i;
      op2_o    <= ~mcr_r[`DUAFR_MCR_OP2];
      rts_o    <= ~mcr_r[`DUAFR_MCR_RTS];
      dtr_o    <= ~mcr_r[`DUAFR_MCR_DTR];
      // modem status interrupt, gated by its enable bit
      irq_o    <= (|dmsr_r) && ier_r[3];
      txrdy_o  <= tx_ready_i;
      mf_o     <= mf_sel;
    end
  end
endmodule // duafr_chan
`default_nettype wire

// *** src/duafr_top.v ***
// dual uart alternate function register, write steering and reset state
`timescale 1ns/1ns
`default_nettype none
`include "duafr_defs.vh"
module duafr_top (
  // clock and reset
  input  wire       clk_sys_i,
  input  wire       rst_b_i,
  // host bus, strobes active high, same clock
  input  wire       wr_i,
  input  wire       rd_i,
  input  wire [2:0] addr_i,
  input  wire [7:0] wdata_i,
  input  wire       channel_select_pin_i,
  output reg  [7:0] rdata_o,
  // modem pins, active low: cd ri dsr cts
  input  wire [3:0] modem_a_b_i,
  input  wire [3:0] modem_b_b_i,
  // datapath status
  input  wire       baud_a_i,
  input  wire       baud_b_i,
  input  wire       rx_ready_a_i,
  input  wire       rx_ready_b_i,
  input  wire       tx_ready_a_i,
  input  wire       tx_ready_b_i,
  input  wire       tx_serial_a_i,
  input  wire       tx_serial_b_i,
  // channel a pins
  output wire       serial_out_a_o,
  output wire       user_output_two_a_o,
  output wire       request_send_out_a_o,
  output wire       terminal_ready_out_a_o,
  output wire       irq_out_a_o,
  output wire       transmit_ready_out_a_o,
  output wire       multi_function_out_a_o,
  // channel b pins
  output wire       serial_out_b_o,
  output wire       user_output_two_b_o,
  output wire       request_send_out_b_o,
  output wire       terminal_ready_out_b_o,
  output wire       irq_out_b_o,
  output wire       transmit_ready_out_b_o,
  output wire       multi_function_out_b_o,
  // register view
  output reg  [7:0] alternate_function_reg_o
);
  reg  [7:0] afr_r;
  wire [3:0] modem_a;
  wire [3:0] modem_b;
  wire [7:0] rdata_a;
  wire [7:0] rdata_b;
  wire [7:0] lcr_a;
  wire [7:0] lcr_b;
  wire       conc;
  wire       wr_a;
  wire       wr_b;
  wire       rd_a;
  wire       rd_b;
  wire       afr_hit;
  wire       sel_dlab;
  assign conc     = afr_r[`DUAFR_AFR_CONC];
  assign wr_a     = wr_i && (conc || !channel_select_pin_i);
  assign wr_b     = wr_i && (conc ||  channel_select_pin_i);
  assign rd_a     = rd_i && !channel_select_pin_i;
  assign rd_b     = rd_i &&  channel_select_pin_i;
  assign sel_dlab = channel_select_pin_i ? lcr_b[`DUAFR_LCR_DLAB] : lcr_a[`DUAFR_LCR_DLAB];
  assign afr_hit  = wr_i && (addr_i == `DUAFR_OFS_AFR) && sel_dlab;
  // one shared copy serves both register sets, so either channel reaches it
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      afr_r <= `DUAFR_RST_ZERO;
    end else if (afr_hit) begin
      afr_r <= wdata_i & `DUAFR_AFR_MASK;
    end
  end
  duafr_sync #(.W(4)) u_sync_a (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .async_i   (~modem_a_b_i),
    .sync_o    (modem_a)
  );
  duafr_sync #(.W(4)) u_sync_b (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .async_i   (~modem_b_b_i),
    .sync_o    (modem_b)
  );
  duafr_chan u_chan_a (
    .clk_sys_i   (clk_sys_i),
    .rst_b_i     (rst_b_i),
    .wr_i        (wr_a),
    .rd_i        (rd_a),
    .addr_i      (addr_i),
    .wdata_i     (wdata_i),
    .rdata_o     (rdata_a),
    .afr_i       (afr_r),
    .modem_i     (modem_a),
    .baud_i      (baud_a_i),
    .rx_ready_i  (rx_ready_a_i),
    .tx_ready_i  (tx_ready_a_i),
    .tx_serial_i (tx_serial_a_i),
    .serial_o    (serial_out_a_o),
    .op2_o       (user_output_two_a_o),
    .rts_o       (request_send_out_a_o),
    .dtr_o       (terminal_ready_out_a_o),
    .irq_o       (irq_out_a_o),
    .txrdy_o     (transmit_ready_out_a_o),
    .mf_o        (multi_function_out_a_o),
    .lcr_o       (lcr_a)
  );
  duafr_chan u_chan_b (
    .clk_sys_i   (clk_sys_i),
    .rst_b_i     (rst_b_i),
    .wr_i        (wr_b),
    .rd_i        (rd_b),
    .addr_i      (addr_i),
    .wdata_i     (wdata_i),
    .rdata_o     (rdata_b),
    .afr_i       (afr_r),
    .modem_i     (modem_b),
    .baud_i      (baud_b_i),
    .rx_ready_i  (rx_ready_b_i),
    .tx_ready_i  (tx_ready_b_i),
    .tx_serial_i (tx_serial_b_i),
    .serial_o    (serial_out_b_o),
    .op2_o       (user_output_two_b_o),
    .rts_o       (request_send_out_b_o),
    .dtr_o       (terminal_ready_out_b_o),
    .irq_o       (irq_out_b_o),
    .txrdy_o     (transmit_ready_out_b_o),
    .mf_o        (multi_function_out_b_o),
    .lcr_o       (lcr_b)
  );
  // registered read data, one cycle after the strobe
  always @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o                  <= 8'h00;
      alternate_function_reg_o <= 8'h00;
    end else begin
      rdata_o                  <= channel_select_pin_i ? rdata_b : rdata_a;
      alternate_function_reg_o <= afr_r;
    end
  end
endmodule // duafr_top
`default_nettype wire

// *** verif/duafr_monitor.sv ***
// assertion checker for the alternate function and reset bank pins
`timescale 1ns/1ns
`default_nettype none
module duafr_monitor (
  // clock, reset and host bus
  input wire logic       clk_sys_i, rst_b_i, wr_i, rd_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] rdata_o,
  // datapath status
  input wire logic       baud_a_i, rx_ready_b_i,
  // pins and register view
  input wire logic       serial_out_a_o, user_output_two_b_o, request_send_out_a_o, terminal_ready_out_b_o,
  input wire logic       irq_out_a_o, transmit_ready_out_b_o, multi_function_out_a_o, multi_function_out_b_o,
  input wire logic [7:0] alternate_function_reg_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  // reset check must run while reset is low, so it overrides the default disable
  a_reset_pin_state:
    assert property (disable iff (1'b0) !rst_b_i |-> serial_out_a_o && user_output_two_b_o
      && request_send_out_a_o && terminal_ready_out_b_o && !irq_out_a_o && !transmit_ready_out_b_o)
    else $error("pin levels wrong during reset");
  a_afr_unused_zero:
    assert property (alternate_function_reg_o[7:3] == 5'h00) else $error("unused afr bits set");
  a_afr_reset_clear:
    assert property ($rose(rst_b_i) |-> alternate_function_reg_o == 8'h00) else $error("afr not clear");
  a_afr_write_cause:
    // the register view lags the write strobe by two samples: one for the register, one for the view
    assert property ($changed(alternate_function_reg_o) |-> $past(wr_i, 2) && $past(addr_i, 2) == 3'h2)
    else $error("afr changed without a write");
  a_mf_reserved_high:
    assert property ((alternate_function_reg_o[2:1] == 2'h3) [*2] |-> multi_function_out_a_o && multi_function_out_b_o)
    else $error("reserved select not high");
  a_mf_baud_sel:
    assert property ((alternate_function_reg_o[2:1] == 2'h1) [*2] |-> multi_function_out_a_o == $past(baud_a_i))
    else $error("mf does not follow baud");
  a_mf_receive_ready_out_sel:
    assert property ((alternate_function_reg_o[2:1] == 2'h2) [*2] |-> multi_function_out_b_o == !$past(rx_ready_b_i))
    else $error("mf does not follow receive ready");
  a_rdata_idle_zero:
    assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("read data without a read");
endmodule // duafr_monitor
bind duafr_top duafr_monitor u_mon (
  .clk_sys_i                (clk_sys_i),
  .rst_b_i                  (rst_b_i),
  .wr_i                     (wr_i),
  .rd_i                     (rd_i),
  .addr_i                   (addr_i),
  .rdata_o                  (rdata_o),
  .baud_a_i                 (baud_a_i),
  .rx_ready_b_i             (rx_ready_b_i),
  .serial_out_a_o           (serial_out_a_o),
  .user_output_two_b_o      (user_output_two_b_o),
  .request_send_out_a_o     (request_send_out_a_o),
  .terminal_ready_out_b_o   (terminal_ready_out_b_o),
  .irq_out_a_o              (irq_out_a_o),
  .transmit_ready_out_b_o   (transmit_ready_out_b_o),
  .multi_function_out_a_o   (multi_function_out_a_o),
  .multi_function_out_b_o   (multi_function_out_b_o),
  .alternate_function_reg_o (alternate_function_reg_o)
);
`default_nettype wire

// *** verif/duafr_host.sv ***
// host processor model driving the parallel register bus
`timescale 1ns/1ns
`default_nettype none
module duafr_host (
  // clock
  input  wire logic       clk_sys_i,
  // strobes, address and data
  output var  logic       wr_i, rd_i, channel_select_pin_i,
  output var  logic [2:0] addr_i,
  output var  logic [7:0] wdata_i
);
  initial begin
    wr_i = 1'b0;
    rd_i = 1'b0;
    channel_select_pin_i = 1'b0;
    addr_i = 3'h0;
    wdata_i = 8'h00;
  end
  // one access per call; released address and data lines show the inverse so stale values are never trusted
  task automatic acc(input logic w, input logic ch, input logic [2:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    wr_i = w;
    rd_i = !w;
    channel_select_pin_i = ch;
    addr_i = a;
    wdata_i = d;
    @(negedge clk_sys_i);
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = ~a;
    wdata_i = ~d;
  endtask
endmodule // duafr_host
`default_nettype wire

// *** verif/tb_dual_uart_alt_function_reset.sv ***
// testbench for the dual uart alternate function and reset bank
`timescale 1ns/1ns
`default_nettype none
module tb_dual_uart_alt_function_reset;
  logic       clk_sys_i = 1'b0, rst_b_i = 1'b1, tx_serial_a_i = 1'b0, tx_serial_b_i = 1'b0;
  logic       baud_a_i = 1'b0, baud_b_i = 1'b0, rx_ready_a_i = 1'b0, rx_ready_b_i = 1'b0;
  logic       tx_ready_a_i = 1'b1, tx_ready_b_i = 1'b1, rd_seen = 1'b0;
  logic [3:0] modem_a_b_i = 4'hf, modem_b_b_i = 4'hf;
  logic [31:0] seed = 32'd55281;
  logic [7:0] expq[$];
  integer     n_fail = 0, checks = 0;
  wire        wr_i, rd_i, channel_select_pin_i;
  wire  [2:0] addr_i;
  wire  [7:0] wdata_i, rdata_o, alternate_function_reg_o;
  wire        serial_out_a_o, user_output_two_a_o, request_send_out_a_o, terminal_ready_out_a_o;
  wire        irq_out_a_o, transmit_ready_out_a_o, multi_function_out_a_o;
  wire        serial_out_b_o, user_output_two_b_o, request_send_out_b_o, terminal_ready_out_b_o;
  wire        irq_out_b_o, transmit_ready_out_b_o, multi_function_out_b_o;
  always #4 clk_sys_i = ~clk_sys_i;
  duafr_top dut (
    .clk_sys_i (clk_sys_i), .rst_b_i (rst_b_i), .wr_i (wr_i), .rd_i (rd_i), .addr_i (addr_i),
    .wdata_i (wdata_i), .channel_select_pin_i (channel_select_pin_i), .rdata_o (rdata_o),
    .modem_a_b_i (modem_a_b_i), .modem_b_b_i (modem_b_b_i), .baud_a_i (baud_a_i), .baud_b_i (baud_b_i),
    .rx_ready_a_i (rx_ready_a_i), .rx_ready_b_i (rx_ready_b_i), .tx_ready_a_i (tx_ready_a_i),
    .tx_ready_b_i (tx_ready_b_i), .tx_serial_a_i (tx_serial_a_i), .tx_serial_b_i (tx_serial_b_i),
    .serial_out_a_o (serial_out_a_o), .user_output_two_a_o (user_output_two_a_o),
    .request_send_out_a_o (request_send_out_a_o), .terminal_ready_out_a_o (terminal_ready_out_a_o),
    .irq_out_a_o (irq_out_a_o), .transmit_ready_out_a_o (transmit_ready_out_a_o),
    .multi_function_out_a_o (multi_function_out_a_o),
    .serial_out_b_o (serial_out_b_o), .user_output_two_b_o (user_output_two_b_o),
    .request_send_out_b_o (request_send_out_b_o), .terminal_ready_out_b_o (terminal_ready_out_b_o),
    .irq_out_b_o (irq_out_b_o), .transmit_ready_out_b_o (transmit_ready_out_b_o),
    .multi_function_out_b_o (multi_function_out_b_o),
    .alternate_function_reg_o (alternate_function_reg_o)
  );
  duafr_host host (
    .clk_sys_i (clk_sys_i), .wr_i (wr_i), .rd_i (rd_i), .channel_select_pin_i (channel_select_pin_i),
    .addr_i (addr_i), .wdata_i (wdata_i)
  );
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic mfx(input int s, input logic op2, input logic bd, input logic rx);
    case (s)
      0: return !op2;
      1: return bd;
      2: return !rx;
      default: return 1'b1;
    endcase
  endfunction
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks = checks + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
    host.acc(1'b1, ch, a, d);
  endtask
  task automatic rd(input logic ch, input logic [2:0] a, input logic [7:0] e);
    expq.push_back(e);
    host.acc(1'b0, ch, a, 8'h00);
  endtask
  // read data stands one cycle after the strobe, so it is taken at the following falling edge
  always @(posedge clk_sys_i) rd_seen <= rd_i;
  always @(negedge clk_sys_i) if (rd_seen) cmp("rdata", expq.pop_front(), rdata_o);
  task automatic rst_chk;
    @(negedge clk_sys_i);
    rst_b_i = 1'b0;
    repeat (6) @(negedge clk_sys_i);
    cmp("high pins", 8'hff, {serial_out_a_o, serial_out_b_o, user_output_two_a_o, user_output_two_b_o,
      request_send_out_a_o, request_send_out_b_o, terminal_ready_out_a_o, terminal_ready_out_b_o});
    cmp("low pins", 8'h00, {4'h0, irq_out_a_o, irq_out_b_o, transmit_ready_out_a_o, transmit_ready_out_b_o});
    rst_b_i = 1'b1;
  endtask
  task automatic final_report;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    // a real falling edge on reset, so the flops are cleared before the first clock edge
    #1 rst_b_i = 1'b0;
    rst_chk();
    for (int ch = 0; ch < 2; ch++) begin
      rd(ch[0], 3'h1, 8'h00);
      rd(ch[0], 3'h2, 8'h01);
      rd(ch[0], 3'h3, 8'h00);
      rd(ch[0], 3'h4, 8'h00);
      rd(ch[0], 3'h5, 8'h60);
      rd(ch[0], 3'h6, 8'h00);
    end
    // enable first: a status read clears the change flag that raises the interrupt
    wr(1'b0, 3'h1, 8'h08);
    modem_a_b_i = 4'he;
    repeat (6) @(negedge clk_sys_i);
    cmp("irq", 8'h02, {6'h0, irq_out_a_o, irq_out_b_o});
    rd(1'b0, 3'h2, 8'h00);
    rd(1'b0, 3'h6, 8'h11);
    rd(1'b0, 3'h6, 8'h10);
    @(negedge clk_sys_i);
    cmp("irq", 8'h00, {6'h0, irq_out_a_o, irq_out_b_o});
    wr(1'b0, 3'h4, 8'h01);
    wr(1'b1, 3'h4, 8'h02);
    wr(1'b0, 3'h3, 8'h80);
    wr(1'b1, 3'h3, 8'h80);
    wr(1'b1, 3'h2, 8'hf9);
    rd(1'b0, 3'h2, 8'h01);
    rd(1'b0, 3'h4, 8'h01);
    rd(1'b1, 3'h4, 8'h02);
    wr(1'b0, 3'h4, 8'h0b);
    rd(1'b1, 3'h4, 8'h0b);
    cmp("mcr pins", 8'h00, {2'h0, user_output_two_a_o, user_output_two_b_o, request_send_out_a_o,
      request_send_out_b_o, terminal_ready_out_a_o, terminal_ready_out_b_o});
    wr(1'b0, 3'h2, 8'h00);
    wr(1'b1, 3'h4, 8'h03);
    rd(1'b0, 3'h4, 8'h0b);
    rd(1'b1, 3'h4, 8'h03);
    for (int s = 0; s < 4; s++) begin
      wr(1'b0, 3'h2, {5'h00, s[1:0], 1'b0});
      rd(1'b1, 3'h2, {5'h00, s[1:0], 1'b0});
      repeat (8) begin
        seed = xs(seed);
        {baud_a_i, baud_b_i, rx_ready_a_i, rx_ready_b_i} = seed[3:0];
        repeat (2) @(negedge clk_sys_i);
        cmp("mf", {6'h0, mfx(s, 1'b1, baud_a_i, rx_ready_a_i), mfx(s, 1'b0, baud_b_i, rx_ready_b_i)},
          {6'h0, multi_function_out_a_o, multi_function_out_b_o});
      end
    end
    rst_chk();
    cmp("afr", 8'h00, alternate_function_reg_o);
    rd(1'b0, 3'h3, 8'h00);
    rd(1'b1, 3'h2, 8'h01);
    repeat (3) @(negedge clk_sys_i);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    n_fail = n_fail + 1;
    final_report();
  end
endmodule // tb_dual_uart_alt_function_reset
`default_nettype wire
